/* File: rtl/clk_sel_pkg.sv */
// Constants for the clock source selection block.
// Assumes a 32-bit APB register bus; all offsets are byte addresses.
package clk_sel_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SRC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] OUT_CTRL_OFS  = 8'h04;
  localparam logic [7:0] STATE_OFS     = 8'h08;
  localparam logic [7:0] EVT_STAT_OFS  = 8'h0c;
  localparam logic [7:0] EVT_CLR_OFS   = 8'h10;
  localparam logic [7:0] EVT_EN_OFS    = 8'h14;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SRC_SEL_LSB   = 6;
  localparam int REF_DIV_LSB   = 3;
  localparam int REF_SEL_BIT   = 2;
  localparam int IREF_OE_BIT   = 1;
  localparam int IREF_STOP_BIT = 0;
  localparam int OUT_DIV_LSB   = 6;
  localparam int MON_EN_BIT    = 2;
  localparam int LOW_PWR_BIT   = 1;
  localparam int PLL_SEL_BIT   = 0;
  localparam logic [7:0] SRC_CTRL_RST = 8'h04;
  localparam logic [7:0] OUT_CTRL_RST = 8'h40;
  // Source select codes
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_IREF = 2'h1;
  localparam logic [1:0] SRC_EREF = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  // Event bits
  localparam int EVT_LOCK   = 0;
  localparam int EVT_UNLOCK = 1;
  localparam int EVT_ELOSS  = 2;
  localparam int EVT_W      = 3;
  // Operating modes
  typedef enum logic [3:0] {
    LOOP_ENGAGED_INTERNAL_MODE, LOOP_ENGAGED_EXTERNAL_MODE,
    LOOP_BYPASSED_INTERNAL_MODE, LOOP_BYPASSED_EXTERNAL_MODE,
    PLL_ENGAGED_EXTERNAL_MODE, PLL_BYPASSED_EXTERNAL_MODE,
    LOW_POWER_INTERNAL_MODE, LOW_POWER_EXTERNAL_MODE, STOP_MODE
  } op_mode_e;
endpackage : clk_sel_pkg

/* File: rtl/system_clock_source_select.sv */
// Clock source selection, reference divider, output divider and
// internal reference gating for the multi clock generator.
// Assumes all clock inputs are levels synchronous to CORE_CLK and
// that they run well below half its rate.
//
// Operation
// - Source field picks loop, internal, external
// - Reserved source code acts as loop
// - Reference divided by two to field power
// - Reference select bit picks internal/external
// - Internal reference output gated by enable
// - Stop keeps internal reference only if allowed
// - Output divider divides by 1,2,4,8
// - Debug clock is loop oscillator halved
// - Nine operating modes decoded
// - Either reference may steer the loop
// - Lock detect interrupt, clock monitor reset
// - Output divider encoding, reset divides by 2
`timescale 1ns/10ps
module system_clock_source_select
  import clk_sel_pkg::*;
(
  input  wire logic                CORE_CLK,     // System clock, 50 MHz
  input  wire logic                RSTN,         // Asynchronous reset, low
  input  wire logic                PSEL,         // APB select
  input  wire logic                PENABLE,      // APB access phase
  input  wire logic                PWRITE,       // APB direction
  input  wire logic [7:0]          PADDR,        // APB byte address
  input  wire logic [31:0]         PWDATA,       // APB write data
  output logic      [31:0]         PRDATA,       // APB read data
  output logic                     PREADY,       // APB ready
  output logic                     PSLVERR,      // APB error
  input  wire logic                INT_REF_CLK,  // Internal reference level
  input  wire logic                EXT_REF_CLK,  // External reference level
  input  wire logic                LOOP_CLK,     // Loop oscillator level
  input  wire logic                PLL_LOCK,     // Lock detector level
  input  wire logic                EXT_REF_LOSS, // Clock monitor loss level
  input  wire logic                STOP_REQ,     // Stop mode request
  output logic                     GEN_OUT_CLK,  // Divided system clock
  output logic                     LOOP_REF_CLK, // Divided loop reference
  output logic                     IREF_OUT_CLK, // Gated internal reference
  output logic                     DBG_HALF_CLK, // Half rate debug clock
  output logic                     IREF_RUN,     // Internal reference running
  output logic                     IRQ,          // Interrupt, high level
  output logic                     MON_RESET     // Clock monitor reset request
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]         src_ctrl_q;
  logic [7:0]         out_ctrl_q;
  logic [EVT_W-1:0]   evt_stat_q;
  logic [EVT_W-1:0]   evt_en_q;
  logic [1:0]         act_src_q;
  logic               sys_lvl_q;
  logic [6:0]         ref_cnt_q;
  logic [2:0]         out_cnt_q;
  logic [1:0]         act_div_q;
  logic               cur_prev_q;
  logic               ref_prev_q;
  logic               sys_prev_q;
  logic               loop_prev_q;
  logic               lock_prev_q;
  logic               loss_prev_q;
  logic               stop_prev_q;
  logic               stop_keep_q;
  op_mode_e           run_mode_q;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire [1:0] src_field = src_ctrl_q[SRC_SEL_LSB+:2];
  wire [2:0] ref_div   = src_ctrl_q[REF_DIV_LSB+:3];
  wire       ref_sel   = src_ctrl_q[REF_SEL_BIT];
  wire       iref_oe   = src_ctrl_q[IREF_OE_BIT];
  wire       iref_stop = src_ctrl_q[IREF_STOP_BIT];
  wire [1:0] out_div   = out_ctrl_q[OUT_DIV_LSB+:2];
  wire       pll_sel   = out_ctrl_q[PLL_SEL_BIT];
  wire       low_pwr   = out_ctrl_q[LOW_PWR_BIT];
  wire       mon_en    = out_ctrl_q[MON_EN_BIT];

  // Mode decode from source, reference and loop settings
  function automatic op_mode_e mode_of(input logic [1:0] src, input logic irs,
                                       input logic pll, input logic lp);
    if (src == SRC_IREF)
      mode_of = lp ? LOW_POWER_INTERNAL_MODE : LOOP_BYPASSED_INTERNAL_MODE;
    else if (src == SRC_EREF)
      mode_of = lp ? LOW_POWER_EXTERNAL_MODE
              : (pll ? PLL_BYPASSED_EXTERNAL_MODE : LOOP_BYPASSED_EXTERNAL_MODE);
    else if (pll)
      mode_of = PLL_ENGAGED_EXTERNAL_MODE;
    else
      mode_of = irs ? LOOP_ENGAGED_INTERNAL_MODE : LOOP_ENGAGED_EXTERNAL_MODE;
  endfunction : mode_of

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire       acc      = PSEL & PENABLE;
  wire       done     = acc & PREADY;
  wire       wr       = done & PWRITE;
  wire       hit_src  = PADDR == SRC_CTRL_OFS;
  wire       hit_out  = PADDR == OUT_CTRL_OFS;
  wire       hit_st   = PADDR == STATE_OFS;
  wire       hit_evt  = PADDR == EVT_STAT_OFS;
  wire       hit_clr  = PADDR == EVT_CLR_OFS;
  wire       hit_en   = PADDR == EVT_EN_OFS;
  wire       mapped   = hit_src | hit_out | hit_st | hit_evt | hit_clr | hit_en;
  wire       stopped  = run_mode_q == STOP_MODE;
  wire [7:0] state_rd = {IREF_RUN, PLL_LOCK, act_src_q, 4'(run_mode_q)};
  wire [31:0] rd_mux  = hit_src ? {24'h0, src_ctrl_q}
                      : hit_out ? {24'h0, out_ctrl_q}
                      : hit_st  ? {24'h0, state_rd}
                      : hit_evt ? {29'h0, evt_stat_q}
                      : hit_en  ? {29'h0, evt_en_q}
                      : 32'h0;

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc & ~PREADY;
      PRDATA  <= (acc & ~PREADY & ~PWRITE) ? rd_mux : 32'h0;
      PSLVERR <= acc & ~PREADY & ~mapped;
    end
  end

  // Control register writes
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      src_ctrl_q <= SRC_CTRL_RST;
      out_ctrl_q <= OUT_CTRL_RST;
      evt_en_q   <= '0;
    end else begin
      if (wr & hit_src) src_ctrl_q <= PWDATA[7:0];
      if (wr & hit_out) out_ctrl_q <= PWDATA[7:0];
      if (wr & hit_en)  evt_en_q   <= PWDATA[EVT_W-1:0];
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  // lock and monitor events; set wins over clear
  wire [EVT_W-1:0] evt_set = {EXT_REF_LOSS & ~loss_prev_q,
                              ~PLL_LOCK & lock_prev_q,
                              PLL_LOCK & ~lock_prev_q};
  wire [EVT_W-1:0] evt_clr = (wr & hit_clr) ? PWDATA[EVT_W-1:0] : '0;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      evt_stat_q  <= '0;
      lock_prev_q <= 1'b0;
      loss_prev_q <= 1'b0;
      IRQ         <= 1'b0;
      MON_RESET   <= 1'b0;
    end else begin
      evt_stat_q  <= (evt_stat_q & ~evt_clr) | evt_set;
      lock_prev_q <= PLL_LOCK;
      loss_prev_q <= EXT_REF_LOSS;
      IRQ         <= |(((evt_stat_q & ~evt_clr) | evt_set) & evt_en_q);
      MON_RESET   <= mon_en & EXT_REF_LOSS;
    end
  end

  // ----------------------------------------
  // Reference divider
  // ----------------------------------------
  // reference choice
  wire ref_lvl  = ref_sel ? INT_REF_CLK : EXT_REF_CLK;
  wire ref_rise = ref_lvl & ~ref_prev_q;
  wire ref_div_lvl = (ref_div == 3'h0) ? ref_lvl : ref_cnt_q[ref_div - 3'h1];

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_prev_q   <= 1'b0;
      ref_cnt_q    <= '0;
      LOOP_REF_CLK <= 1'b0;
    end else begin
      ref_prev_q   <= ref_lvl;
      if (ref_rise) ref_cnt_q <= ref_cnt_q + 7'h1;
      LOOP_REF_CLK <= ref_div_lvl & ~stopped;
    end
  end

  // ----------------------------------------
  // System source switch and output divider
  // ----------------------------------------
  // reserved code behaves as loop
  wire [1:0] want_src = (src_field == SRC_RSVD) ? SRC_LOOP : src_field;

  // Level of a source by code
  function automatic logic src_lvl(input logic [1:0] s, input logic lp,
                                   input logic ir, input logic er);
    case (s)
      SRC_IREF: src_lvl = ir;
      SRC_EREF: src_lvl = er;
      default:  src_lvl = lp;
    endcase
  endfunction : src_lvl

  // Output divider tap: the undivided level or one counter bit
  function automatic logic div_bit(input logic [1:0] d, input logic lvl,
                                   input logic [2:0] cnt);
    case (d)
      2'h0:    div_bit = lvl;
      2'h1:    div_bit = cnt[0];
      2'h2:    div_bit = cnt[1];
      default: div_bit = cnt[2];
    endcase
  endfunction : div_bit

  wire cur_lvl  = src_lvl(act_src_q, LOOP_CLK, INT_REF_CLK, EXT_REF_CLK);
  wire new_lvl  = src_lvl(want_src, LOOP_CLK, INT_REF_CLK, EXT_REF_CLK);
  // switch only while both clocks are low
  wire can_swap = (want_src != act_src_q) & ~sys_lvl_q & ~cur_lvl & ~new_lvl;
  // rise only on true edge, never mid-phase after stop
  wire sys_d    = can_swap ? 1'b0
                : cur_lvl & ~stopped & (sys_lvl_q | ~cur_prev_q);
  wire sys_rise = sys_lvl_q & ~sys_prev_q;
  wire out_lvl  = div_bit(act_div_q, sys_lvl_q, out_cnt_q);
  wire new_div  = div_bit(out_div, sys_lvl_q, out_cnt_q);
  // divider change waits for both taps low
  wire div_swap = (out_div != act_div_q) & ~out_lvl & ~new_div;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      act_src_q   <= SRC_LOOP;
      act_div_q   <= OUT_CTRL_RST[OUT_DIV_LSB+:2];
      sys_lvl_q   <= 1'b0;
      sys_prev_q  <= 1'b0;
      cur_prev_q  <= 1'b0;
      out_cnt_q   <= '0;
      GEN_OUT_CLK <= 1'b0;
    end else begin
      if (can_swap) act_src_q <= want_src;
      if (div_swap) act_div_q <= out_div;
      sys_lvl_q   <= sys_d;
      sys_prev_q  <= sys_lvl_q;
      cur_prev_q  <= cur_lvl;
      // Divider restarts after stop so the first pulse is whole
      if (stopped)       out_cnt_q <= '0;
      else if (sys_rise) out_cnt_q <= out_cnt_q + 3'h1;
      GEN_OUT_CLK <= out_lvl & ~stopped;
    end
  end

  // ----------------------------------------
  // Debug half clock
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      loop_prev_q  <= 1'b0;
      DBG_HALF_CLK <= 1'b0;
    end else begin
      loop_prev_q  <= LOOP_CLK;
      if (LOOP_CLK & ~loop_prev_q) DBG_HALF_CLK <= ~DBG_HALF_CLK;
    end
  end

  // ----------------------------------------
  // Mode tracking, stop and internal reference
  // ----------------------------------------
  // The keep decision must see the mode held before stop, so it is
  // latched on the stop request edge rather than read while stopped.
  wire      stop_in   = STOP_REQ & ~stop_prev_q;
  wire      iref_mode = (run_mode_q == LOOP_ENGAGED_INTERNAL_MODE)
                      | (run_mode_q == LOOP_BYPASSED_INTERNAL_MODE)
                      | (run_mode_q == LOW_POWER_INTERNAL_MODE);
  wire      keep_now  = iref_stop & (iref_oe | iref_mode);
  wire      iref_on   = stopped ? stop_keep_q : 1'b1;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      stop_prev_q  <= 1'b0;
      stop_keep_q  <= 1'b0;
      run_mode_q   <= LOOP_ENGAGED_INTERNAL_MODE;
      IREF_RUN     <= 1'b1;
      IREF_OUT_CLK <= 1'b0;
    end else begin
      stop_prev_q <= STOP_REQ;
      if (stop_in) stop_keep_q <= keep_now;
      run_mode_q  <= STOP_REQ ? STOP_MODE
                   : mode_of(want_src, ref_sel, pll_sel, low_pwr);
      IREF_RUN    <= STOP_REQ ? (stop_in ? keep_now : stop_keep_q) : 1'b1;
      IREF_OUT_CLK <= INT_REF_CLK & iref_oe & iref_on;
    end
  end

endmodule : system_clock_source_select

/* File: tb/osc_model.sv */
// Free running oscillator model for the clock select bench.
// Assumes the core clock; the level toggles every HALF core cycles.
`timescale 1ns/10ps
module osc_model #(
  parameter int HALF = 5
) (
  input  wire logic clk, // Core clock
  output logic      q    // Oscillator level
);
  int cnt = 0;
  initial q = 1'b0;
  // Toggle after HALF cycles
  always @(posedge clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      q   <= ~q;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : osc_model

/* File: tb/system_clock_source_select_asserts.sv */
// Port checker for the clock source select block.
// Assumes reference levels slower than a quarter of the core clock.
`timescale 1ns/10ps
module system_clock_source_select_asserts (
  input wire logic        CORE_CLK,     // Clock
  input wire logic        RSTN,         // Reset, low
  input wire logic        PSEL,         // Select
  input wire logic        PENABLE,      // Access
  input wire logic        PREADY,       // Ready
  input wire logic        PSLVERR,      // Error
  input wire logic [31:0] PRDATA,       // Read data
  input wire logic        INT_REF_CLK,  // Int ref
  input wire logic        LOOP_CLK,     // Loop osc
  input wire logic        EXT_REF_LOSS, // Loss level
  input wire logic        STOP_REQ,     // Stop
  input wire logic        GEN_OUT_CLK,  // Sys clock
  input wire logic        LOOP_REF_CLK, // Loop ref
  input wire logic        IREF_OUT_CLK, // Gated ref
  input wire logic        DBG_HALF_CLK, // Debug clk
  input wire logic        IREF_RUN,     // Ref running
  input wire logic        MON_RESET     // Monitor reset
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  a_ready_wait: assert property (PREADY |-> $past(PSEL) && $past(PENABLE) &&
    $past(PSEL, 2) && !$past(PENABLE, 2)) else $error("ready not after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray data");
  a_iref_gated: assert property (IREF_OUT_CLK |-> $past(INT_REF_CLK) ||
    $past(INT_REF_CLK, 2) || $past(INT_REF_CLK, 3) || $past(INT_REF_CLK, 4))
    else $error("gated ref high without source");
  a_dbg_toggle: assert property ($changed(DBG_HALF_CLK) |-> $past(LOOP_CLK) ||
    $past(LOOP_CLK, 2) || $past(LOOP_CLK, 3)) else $error("debug clock stray edge");
  a_mon_cause: assert property (MON_RESET |-> $past(EXT_REF_LOSS))
    else $error("monitor reset without loss");
  a_stop_quiet: assert property (STOP_REQ [*4] |-> !GEN_OUT_CLK && !LOOP_REF_CLK)
    else $error("clocks run in stop");
  a_stop_hold: assert property (STOP_REQ [*4] |-> $stable(IREF_RUN))
    else $error("run flag moves in stop");
  a_no_glitch: assert property ($rose(GEN_OUT_CLK) |=> (GEN_OUT_CLK || STOP_REQ) [*4])
    else $error("short system clock pulse");
  c_err: cover property (PSLVERR);
  c_keep: cover property (STOP_REQ [*4] ##0 IREF_RUN);
  c_mon: cover property (MON_RESET);
endmodule : system_clock_source_select_asserts

bind system_clock_source_select system_clock_source_select_asserts chk_u (.CORE_CLK,
  .RSTN, .PSEL, .PENABLE, .PREADY, .PSLVERR, .PRDATA, .INT_REF_CLK, .LOOP_CLK,
  .EXT_REF_LOSS, .STOP_REQ, .GEN_OUT_CLK, .LOOP_REF_CLK, .IREF_OUT_CLK, .DBG_HALF_CLK,
  .IREF_RUN, .MON_RESET);

/* File: tb/system_clock_source_select_tb.sv */
// Self-checking bench for the clock source select block.
// Assumes oscillator models with half periods of 5, 7 and 11 cycles.
`timescale 1ns/10ps
module system_clock_source_select_tb;
  import clk_sel_pkg::*;
  localparam int IH = 5, EH = 7, LH = 11;
  logic CORE_CLK, RSTN, PSEL, PENABLE, PWRITE, PLL_LOCK, EXT_REF_LOSS, STOP_REQ, err_q;
  logic PREADY, PSLVERR, INT_REF_CLK, EXT_REF_CLK, LOOP_CLK, GEN_OUT_CLK, LOOP_REF_CLK;
  logic IREF_OUT_CLK, DBG_HALF_CLK, IREF_RUN, IRQ, MON_RESET, f;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd_q;
  logic [2:0]  d;
  logic [1:0]  c, b;
  logic [7:0]  sk [5] = '{8'h01, 8'h05, 8'h83, 8'h04, 8'h45};
  logic [3:0]  sm [5] = '{4'h1, 4'h0, 4'h3, 4'h0, 4'h2};
  logic        se [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0]  po [4] = '{8'h41, 8'h41, 8'h42, 8'h42};
  logic [1:0]  ps [4] = '{SRC_LOOP, SRC_EREF, SRC_IREF, SRC_EREF};
  wire  [3:0]  mon = {DBG_HALF_CLK, IREF_OUT_CLK, LOOP_REF_CLK, GEN_OUT_CLK};
  int          mismatches = 0, compares = 0, n;
  system_clock_source_select dut_u (.CORE_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .INT_REF_CLK, .EXT_REF_CLK, .LOOP_CLK, .PLL_LOCK,
    .EXT_REF_LOSS, .STOP_REQ, .GEN_OUT_CLK, .LOOP_REF_CLK, .IREF_OUT_CLK, .DBG_HALF_CLK,
    .IREF_RUN, .IRQ, .MON_RESET);
  osc_model #(.HALF(IH)) int_u (.clk(CORE_CLK), .q(INT_REF_CLK));
  osc_model #(.HALF(EH)) ext_u (.clk(CORE_CLK), .q(EXT_REF_CLK));
  osc_model #(.HALF(LH)) loop_u (.clk(CORE_CLK), .q(LOOP_CLK));
  // ----------------------------------------
  // Clock, helpers and checks
  // ----------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  function int gen_half(input logic [1:0] s, input logic [1:0] o);
    return (s == SRC_IREF ? IH : s == SRC_EREF ? EH : LH) << o;
  endfunction : gen_half
  // software picks the smallest divider reaching the window
  function logic [2:0] ref_pick(input int h, input int lo);
    ref_pick = 3'h7;
    for (int k = 7; k >= 0; k--) begin
      if ((h << k) >= lo) ref_pick = 3'(k);
    end
  endfunction : ref_pick
  task test_done;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, then one idle edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= v;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    rd_q    = PRDATA;
    err_q   = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  // Half period of a watched clock, 0 when it stands still
  task meas(input int s, output int h);
    logic v;
    int   k;
    k = 0;
    h = 0;
    @(posedge CORE_CLK);
    v = mon[s];
    do begin @(posedge CORE_CLK); k++; end while (mon[s] === v && k < 1000);
    v = mon[s];
    do begin @(posedge CORE_CLK); h++; end while (mon[s] === v && h < 1000);
    if (h >= 1000) h = 0;
  endtask : meas
  task wt;
    repeat (3) @(posedge CORE_CLK);
  endtask : wt
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, PLL_LOCK, EXT_REF_LOSS, STOP_REQ} = '0;
    PADDR  = 8'h00;
    PWDATA = 32'h0;
    repeat (2) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    void'($urandom(90));
    rd(SRC_CTRL_OFS, 32'h04);
    rd(OUT_CTRL_OFS, 32'h40);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err_q), 32'h1);
    $display("done: registers");
    for (int i = 0; i < 10; i++) begin
      c = (i < 4) ? 2'(i) : 2'($urandom);
      d = (i == 3) ? 3'h7 : 3'($urandom);
      b = (i == 2) ? 2'h3 : 2'($urandom);
      f = 1'($urandom);
      apb(1'b1, SRC_CTRL_OFS, {24'h0, c, d, f, 2'b00});
      apb(1'b1, OUT_CTRL_OFS, {24'h0, b, 6'h00});
      repeat (3) meas(0, n);
      chk(32'(n), 32'(gen_half(c, b)));
      repeat (3) meas(1, n);
      chk(32'(n), 32'((f ? IH : EH) << d));
    end
    $display("done: dividers");
    apb(1'b1, SRC_CTRL_OFS, 32'h04);
    meas(2, n);
    chk(32'(n), 32'h0);
    apb(1'b1, SRC_CTRL_OFS, 32'h06);
    repeat (2) meas(2, n);
    chk(32'(n), 32'(IH));
    repeat (2) meas(3, n);
    chk(32'(n), 32'(2 * LH));
    $display("done: gated clocks");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, SRC_CTRL_OFS, {24'h0, sk[i]});
      repeat (40) @(posedge CORE_CLK);
      apb(1'b0, STATE_OFS, 32'h0);
      chk(32'(rd_q[3:0]), 32'(sm[i]));
      STOP_REQ <= 1'b1;
      repeat (6) @(posedge CORE_CLK);
      chk(32'(IREF_RUN), 32'(se[i]));
      apb(1'b0, STATE_OFS, 32'h0);
      chk(32'(rd_q[3:0]), 32'h8);
      STOP_REQ <= 1'b0;
      repeat (6) @(posedge CORE_CLK);
    end
    $display("done: stop");
    // PLL engaged, PLL bypassed and low-power modes set up by software
    d = ref_pick(EH, 48);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OUT_CTRL_OFS, {24'h0, po[i]});
      apb(1'b1, SRC_CTRL_OFS, {24'h0, ps[i], d, ps[i] == SRC_IREF, 2'b00});
      repeat (40) @(posedge CORE_CLK);
      apb(1'b0, STATE_OFS, 32'h0);
      chk(32'(rd_q[3:0]), 32'(PLL_ENGAGED_EXTERNAL_MODE) + 32'(i));
      repeat (3) meas(0, n);
      chk(32'(n), 32'(gen_half(ps[i], 2'h1)));
      repeat (3) meas(1, n);
      chk(32'(n), 32'((ps[i] == SRC_IREF ? IH : EH) << d));
    end
    $display("done: modes");
    PLL_LOCK <= 1'b1;
    wt();
    rd(EVT_STAT_OFS, 32'h1);
    chk(32'(IRQ), 32'h0);
    apb(1'b1, EVT_EN_OFS, 32'h7);
    wt();
    chk(32'(IRQ), 32'h1);
    apb(1'b1, EVT_CLR_OFS, 32'h1);
    wt();
    chk(32'(IRQ), 32'h0);
    rd(EVT_CLR_OFS, 32'h0);
    PLL_LOCK     <= 1'b0;
    EXT_REF_LOSS <= 1'b1;
    apb(1'b1, OUT_CTRL_OFS, 32'h44);
    wt();
    rd(EVT_STAT_OFS, 32'h6);
    chk(32'(MON_RESET), 32'h1);
    EXT_REF_LOSS <= 1'b0;
    apb(1'b1, EVT_CLR_OFS, 32'h7);
    wt();
    chk(32'(IRQ) | 32'(MON_RESET), 32'h0);
    $display("done: events");
    test_done();
  end
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge CORE_CLK);
    mismatches++;
    test_done();
  end
endmodule : system_clock_source_select_tb
